// *** core/pmc_ctrl.sv ***
// Page-mode, two-bank interleaving DRAM controller core.
// Assumes all pins arrive asynchronously and are bundled in one pin struct.
//
// Summary of operation
// - Capture upper address on row strobe; compare.
// - Page hit completes with zero wait states.
// - Page miss runs two waits via ready.
// - Hold acknowledge picks status or bus strobes.
// - Decode cycle type from status and select.
// - Processor cycle ends on cycle-done low.
// - Normal mode: wait selects give 0/1 waits.
// - Page mode select low runs page accesses.
// - Strobes only for on-board memory addresses or shadow copy writes.
// - Refresh forces the row/column mux low.
// - Bank chosen from column and row enables unless interleaving.
// - Shadow copy writes still produce strobes.
// - Reset and interrupt outputs are inverted inputs.
// - Low-byte column strobe from address bit 0.
// - High-byte column strobe from high enable.
// - Timebase measures row strobe active time.
// - Interleave only when enabled and paging.
// - Hold uses external bit 9 for bank.
// - Test low floats every output.
// - Zero-wait output pulled low when wanted.
// - Mux lags row strobe except zero-wait.
// - Early writes low second phase, high end.
// - Page-mode writes precharge with two waits.
// - About 10 us row activity forces miss.
// - Bus read/write strobes synchronised before use.
`timescale 1ns/1ps
module pmc_ctrl (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire pmc_pkg::pmc_pins_t i_pins,
    output logic [1:0] o_row_strobes_b0_n,
    output logic [1:0] o_row_strobes_b1_n,
    output logic o_col_strobe_b0_lo_n,
    output logic o_col_strobe_b0_hi_n,
    output logic o_col_strobe_b1_lo_n,
    output logic o_col_strobe_b1_hi_n,
    output logic o_row_col_mux_sel,
    output logic o_early_write_a_n,
    output logic o_early_write_b_n,
    output logic o_zero_wait_req_out,
    output logic o_zero_wait_req_oe,
    output logic o_bus_ready_out,
    output logic o_bus_ready_oe,
    output logic o_reset_n,
    output logic o_rtc_irq_out,
    output logic o_pins_oe
);
    import pmc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    pmc_pins_t p;
    logic [PINS_W-1:0] pins_q;

    // strobe synchronisers
    // Pins pass the flops flipped against their idle level, so a reset never fakes a request or an interrupt.
    pmc_sync3 #(.W(PINS_W)) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_d(i_pins ^ PINS_IDLE),
        .o_q(pins_q)
    );
    assign p = pmc_pins_t'(pins_q ^ PINS_IDLE);

    ////////////////////////////////////////////////////////////////////////////////
    pmc_state_t state, next_state;
    logic bank, next_bank;
    logic is_wr, next_is_wr;
    logic lo_n, next_lo_n;
    logic hi_n, next_hi_n;
    logic [1:0] wcnt, next_wcnt;
    logic [1:0] open, next_open;
    logic [TAG_W-1:0] tag0, next_tag0;
    logic [TAG_W-1:0] tag1, next_tag1;
    logic [1:0] ras_n, next_ras_n;
    logic [3:0] cas_n, next_cas_n;
    logic mux, next_mux;
    logic wr_n, next_wr_n;
    logic zw, next_zw;
    logic rdy_low, next_rdy_low;
    logic armed, next_armed;
    logic [7:0] tb_cnt, next_tb_cnt;
    logic force_miss, next_force_miss;
    logic tb_prev;
    logic drive;

    logic hold, page_mode, ilv, a9, sel_bank1, qual, page_hit, end_cyc, start, fast_norm;
    logic [1:0] row_mask, waits;
    pmc_cyc_t cyc;
    logic [TAG_W-1:0] tag_sel;

    always_comb begin
        hold = p.hold_ack_in;
        page_mode = !p.page_mode_n;
        ilv = !p.interleave_en_n && page_mode;
        a9 = hold ? p.ext_addr_bit9 : p.cpu_addr_bit9;
        if (hold) begin
            cyc = !p.bus_mem_write_n ? CYC_WRITE : (!p.bus_mem_read_n ? CYC_READ : CYC_NONE);
            end_cyc = p.bus_mem_write_n && p.bus_mem_read_n;
        end else begin
            cyc = pmc_cpu_cycle(p.cpu_status1_n, p.cpu_status0_n, p.mem_io_sel);
            end_cyc = !p.cycle_done_n;
        end
        sel_bank1 = ilv ? a9 : (p.bank1_col_enable && p.bank1_row_enable && !p.bank0_row_enable);
        row_mask = ilv ? (sel_bank1 ? 2'b10 : 2'b01) : 2'b11;
        qual = p.onboard_mem_hit || (p.shadow_copy_active && cyc == CYC_WRITE);
        tag_sel = sel_bank1 ? tag1 : tag0;
        page_hit = page_mode && cyc == CYC_READ && open[sel_bank1] && tag_sel == p.upper_addr_bits
                   && !force_miss;
        start = state == ST_IDLE && armed && cyc != CYC_NONE && qual;
        waits = (cyc == CYC_WRITE) ? {1'b0, p.write_wait_sel} : {1'b0, p.read_wait_sel};
        fast_norm = !page_mode && waits == 2'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        next_bank = bank;
        next_is_wr = is_wr;
        next_lo_n = lo_n;
        next_hi_n = hi_n;
        next_wcnt = wcnt;
        next_open = open;
        next_tag0 = tag0;
        next_tag1 = tag1;
        next_ras_n = ras_n;
        next_cas_n = cas_n;
        next_mux = mux;
        next_wr_n = wr_n;
        next_zw = zw;
        next_rdy_low = rdy_low;
        next_armed = armed;
        case (state)
            ST_IDLE: begin
                if (cyc == CYC_NONE) begin
                    next_armed = 1'b1;
                end
                if (start) begin
                    next_armed = 1'b0;
                    next_bank = sel_bank1;
                    next_is_wr = cyc == CYC_WRITE;
                    next_lo_n = hold ? p.ext_addr_bit0 : p.cpu_addr_bit0;
                    next_hi_n = hold ? p.ext_high_byte_en_n : p.cpu_high_byte_en_n;
                    if (page_hit) begin
                        next_state = ST_COL;
                        next_wcnt = 2'h0;
                        next_zw = !hold;
                        next_mux = 1'b1;
                        next_cas_n = {~(sel_bank1 && !next_hi_n), ~(sel_bank1 && !next_lo_n),
                                      ~(!sel_bank1 && !next_hi_n), ~(!sel_bank1 && !next_lo_n)};
                    end else if (page_mode) begin
                        next_wcnt = WAIT_MISS;
                        next_rdy_low = !hold;
                        next_state = (ras_n != ROWS_OFF) ? ST_PRECH : ST_ROW;
                        next_ras_n = ROWS_OFF;
                        next_open = BANKS_RST;
                        next_wcnt = (ras_n != ROWS_OFF) ? WAIT_MISS : WAIT_MISS;
                    end else begin
                        next_wcnt = waits;
                        next_rdy_low = !hold && waits != 2'h0;
                        next_state = ST_ROW;
                    end
                    if (!page_hit && (ras_n == ROWS_OFF || !page_mode)) begin
                        next_ras_n = ~row_mask;
                        next_open = row_mask;
                        next_tag0 = row_mask[0] ? p.upper_addr_bits : tag0;
                        next_tag1 = row_mask[1] ? p.upper_addr_bits : tag1;
                        next_mux = fast_norm;
                    end
                end
            end
            ST_PRECH: begin
                next_state = ST_ROW;
                next_ras_n = ~row_mask;
                next_open = row_mask;
                next_tag0 = row_mask[0] ? p.upper_addr_bits : tag0;
                next_tag1 = row_mask[1] ? p.upper_addr_bits : tag1;
                next_mux = 1'b0;
            end
            ST_ROW: begin
                next_state = ST_COL;
                next_mux = 1'b1;
                next_cas_n = {~(bank && !hi_n), ~(bank && !lo_n), ~(!bank && !hi_n), ~(!bank && !lo_n)};
                if (!ilv) begin
                    next_cas_n = {hi_n, lo_n, hi_n, lo_n} | (bank ? 4'h3 : 4'hc);
                end
            end
            ST_COL: begin
                next_wr_n = !is_wr;
                if (wcnt != 2'h0) begin
                    next_wcnt = wcnt - 2'h1;
                    next_rdy_low = wcnt != 2'h1 && !hold;
                end else if (end_cyc) begin
                    next_state = ST_IDLE;
                    next_cas_n = COLS_OFF;
                    next_wr_n = 1'b1;
                    next_zw = 1'b0;
                    next_rdy_low = 1'b0;
                    if (!page_mode) begin
                        next_ras_n = ROWS_OFF;
                        next_open = BANKS_RST;
                        next_mux = 1'b0;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (!p.refresh_n) begin
            next_mux = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The timebase is slow and asynchronous, so only its synchronised rising edge counts.
    always_comb begin
        next_tb_cnt = tb_cnt;
        next_force_miss = force_miss;
        if (ras_n == ROWS_OFF) begin
            next_tb_cnt = TB_CNT_RST;
            next_force_miss = 1'b0;
        end else if (p.fixed_timebase && !tb_prev && !force_miss) begin
            next_tb_cnt = tb_cnt + 8'h01;
            next_force_miss = next_tb_cnt == TB_TICKS;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_IDLE;
            bank <= 1'b0;
            is_wr <= 1'b0;
            lo_n <= 1'b1;
            hi_n <= 1'b1;
            wcnt <= 2'h0;
            open <= BANKS_RST;
            tag0 <= TAG_RST;
            tag1 <= TAG_RST;
            ras_n <= ROWS_OFF;
            cas_n <= COLS_OFF;
            mux <= 1'b0;
            wr_n <= 1'b1;
            zw <= 1'b0;
            rdy_low <= 1'b0;
            armed <= 1'b0;
            tb_cnt <= TB_CNT_RST;
            force_miss <= 1'b0;
            tb_prev <= 1'b0;
            drive <= 1'b0;
            o_reset_n <= 1'b0;
            o_rtc_irq_out <= 1'b0;
        end else begin
            state <= next_state;
            bank <= next_bank;
            is_wr <= next_is_wr;
            lo_n <= next_lo_n;
            hi_n <= next_hi_n;
            wcnt <= next_wcnt;
            open <= next_open;
            tag0 <= next_tag0;
            tag1 <= next_tag1;
            ras_n <= next_ras_n;
            cas_n <= next_cas_n;
            mux <= next_mux;
            wr_n <= next_wr_n;
            zw <= next_zw;
            rdy_low <= next_rdy_low;
            armed <= next_armed;
            tb_cnt <= next_tb_cnt;
            force_miss <= next_force_miss;
            tb_prev <= p.fixed_timebase;
            drive <= p.test_n;
            o_reset_n <= 1'b1;
            o_rtc_irq_out <= !p.rtc_irq_in_n;
        end
    end

    // Strobe pins mirror the internal state flops directly.
    assign o_row_strobes_b0_n = {ras_n[0], ras_n[0]};
    assign o_row_strobes_b1_n = {ras_n[1], ras_n[1]};
    assign o_col_strobe_b0_lo_n = cas_n[0];
    assign o_col_strobe_b0_hi_n = cas_n[1];
    assign o_col_strobe_b1_lo_n = cas_n[2];
    assign o_col_strobe_b1_hi_n = cas_n[3];
    assign o_row_col_mux_sel = mux;
    assign o_early_write_a_n = wr_n;
    assign o_early_write_b_n = wr_n;
    assign o_zero_wait_req_out = 1'b0;
    assign o_zero_wait_req_oe = zw && drive;
    assign o_bus_ready_out = 1'b0;
    assign o_bus_ready_oe = rdy_low && drive;
    assign o_pins_oe = drive;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    AST_TAG_CAPTURE: assert property ($fell(ras_n[0]) |-> tag0 == $past(p.upper_addr_bits))
        else $error("Bank 0 tag not captured on row strobe.");
    AST_HIT_ZERO_WAIT: assert property (start && page_hit && !hold |=> zw && state == ST_COL && !rdy_low)
        else $error("Page hit did not complete zero-wait.");
    AST_MISS_WAITS: assert property (start && !page_hit && page_mode && !hold |=> rdy_low ##1 rdy_low)
        else $error("Page miss did not extend the cycle.");
    AST_MUX_LAG: assert property ($past(ras_n) == ROWS_OFF && ras_n != ROWS_OFF
        && page_mode && p.refresh_n |-> !mux ##1 mux)
        else $error("Mux select did not lag the row strobes.");
    AST_CPU_END: assert property (state == ST_COL && wcnt == 2'h0 && !hold && !p.cycle_done_n
        |=> state == ST_IDLE && cas_n == COLS_OFF)
        else $error("Cycle-done did not end the access.");
    AST_REFRESH_MUX: assert property (!p.refresh_n |=> !mux)
        else $error("Mux select not forced low in refresh.");
    AST_IRQ_INVERT: assert property (o_rtc_irq_out == !$past(p.rtc_irq_in_n))
        else $error("Interrupt output not inverted input.");
    AST_TEST_FLOAT: assert property (!p.test_n |=> !o_pins_oe && !o_zero_wait_req_oe && !o_bus_ready_oe)
        else $error("Outputs not floated in test.");
    AST_ZW_ONLY_COL: assert property (o_zero_wait_req_oe |-> state == ST_COL)
        else $error("Zero-wait driven outside column phase.");
    AST_WRITE_RELEASE: assert property (state == ST_COL && wcnt == 2'h0 && end_cyc |=> wr_n)
        else $error("Early write not released at cycle end.");
    AST_FORCE_MISS: assert property (force_miss && start && page_mode |=> ras_n == ROWS_OFF)
        else $error("Timeout did not force a page miss.");
    AST_IDLE_RESET: assert property ($rose(o_reset_n) |-> ras_n == ROWS_OFF && open == BANKS_RST)
        else $error("Strobes not idle after reset.");

endmodule // pmc_ctrl

// *** core/pmc_pkg.sv ***
// Shared constants, pin bundle and cycle types for the page-mode DRAM controller.
// Assumes one 200 MHz clock; every pin is resynchronised before use.
package pmc_pkg;

    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned RAS_MAX_NS = 10000;
    // Period of the fixed timebase; plain default, set to the board's oscillator.
    localparam int unsigned TB_PERIOD_NS = 70;
    // Longest time rounds down to whole timebase ticks.
    localparam int unsigned TB_TICKS_INT = RAS_MAX_NS / TB_PERIOD_NS;
    localparam logic [7:0] TB_TICKS = TB_TICKS_INT[7:0];
    localparam logic [1:0] PRECH_CYC = 2'h1;
    localparam logic [1:0] WAIT_MISS = 2'h2;
    localparam int unsigned TAG_W = 15;
    localparam logic [TAG_W-1:0] TAG_RST = 15'h0000;
    localparam logic [7:0] TB_CNT_RST = 8'h00;
    localparam logic [1:0] BANKS_RST = 2'h0;
    localparam logic [1:0] ROWS_OFF = 2'h3;
    localparam logic [3:0] COLS_OFF = 4'hf;

    typedef struct packed {
        logic [TAG_W-1:0] upper_addr_bits;
        logic cpu_addr_bit9;
        logic ext_addr_bit9;
        logic cpu_addr_bit0;
        logic cpu_high_byte_en_n;
        logic ext_addr_bit0;
        logic ext_high_byte_en_n;
        logic hold_ack_in;
        logic cpu_status0_n;
        logic cpu_status1_n;
        logic mem_io_sel;
        logic cycle_done_n;
        logic bus_mem_read_n;
        logic bus_mem_write_n;
        logic write_wait_sel;
        logic read_wait_sel;
        logic onboard_mem_hit;
        logic refresh_n;
        logic bank0_col_enable;
        logic bank1_col_enable;
        logic bank0_row_enable;
        logic bank1_row_enable;
        logic shadow_copy_active;
        logic page_mode_n;
        logic interleave_en_n;
        logic test_n;
        logic fixed_timebase;
        logic rtc_irq_in_n;
    } pmc_pins_t;

    localparam int unsigned PINS_W = $bits(pmc_pins_t);

    // Idle level of every pin, so that the synchroniser leaves reset showing no request and no interrupt.
    localparam pmc_pins_t PINS_IDLE = '{cpu_high_byte_en_n: 1'b1, ext_high_byte_en_n: 1'b1,
        cpu_status0_n: 1'b1, cpu_status1_n: 1'b1, cycle_done_n: 1'b1, bus_mem_read_n: 1'b1,
        bus_mem_write_n: 1'b1, refresh_n: 1'b1, interleave_en_n: 1'b1, test_n: 1'b1,
        rtc_irq_in_n: 1'b1, default: '0};

    typedef enum logic [1:0] {
        CYC_NONE = 2'b00,
        CYC_READ = 2'b01,
        CYC_WRITE = 2'b10
    } pmc_cyc_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PRECH = 2'b01,
        ST_ROW = 2'b10,
        ST_COL = 2'b11
    } pmc_state_t;

    // Processor status decode: memory read is status1 low, memory write is status0 low.
    function automatic pmc_cyc_t pmc_cpu_cycle(input logic s1_n, input logic s0_n, input logic mio);
        pmc_cyc_t c;
        c = CYC_NONE;
        if (mio && !s1_n && s0_n) begin
            c = CYC_READ;
        end else if (mio && s1_n && !s0_n) begin
            c = CYC_WRITE;
        end
        return c;
    endfunction

endpackage

// *** core/pmc_sync3.sv ***
// Three-stage input synchroniser for pins from outside the clock domain.
// Assumes the outputs settle only when the second and third stages agree.
`timescale 1ns/1ps
module pmc_sync3 #(
    parameter int unsigned W = 1
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    // A bit moves only once it has held across two stages, filtering one-stage glitches.
    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_q[i] = (s2[i] == s3[i]) ? s3[i] : o_q[i];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            o_q <= '0;
        end else begin
            s1 <= i_d;
            s2 <= s1;
            s3 <= s2;
            o_q <= next_q;
        end
    end

endmodule // pmc_sync3

// *** tb/pmc_bus_model.sv ***
// Processor-side partner: answers with the cycle-done input and runs the fixed timebase.
// Assumes the bench raises i_active for the whole of each processor cycle.
`timescale 1ns/1ps
module pmc_bus_model (
    input wire logic i_ref_clk,
    input wire logic i_active,
    input wire logic i_col_low,
    input wire logic i_ready_oe,
    input wire logic [3:0] i_delay,
    output logic o_cycle_done_n,
    output logic o_timebase
);
    int cnt;
    initial begin
        o_cycle_done_n = 1'b1;
        o_timebase = 1'b0;
        cnt = 0;
    end
    always #35 o_timebase = ~o_timebase;
    ////////////////////////////////////////////////////////////////////////
    // done only after waits
    // Done is held back until the controller stops stretching, as a real CPU would.
    always @(negedge i_ref_clk) begin
        if (!i_active) begin
            cnt = 0;
            o_cycle_done_n <= 1'b1;
        end else if (i_col_low && !i_ready_oe) begin
            cnt++;
            if (cnt > i_delay) begin
                o_cycle_done_n <= 1'b0;
            end
        end
    end
endmodule // pmc_bus_model

// *** tb/tb_top.sv ***
// Self-checking bench for the page-mode DRAM controller.
// Assumes pins settle through the controller's three-flop synchronisers.
`timescale 1ns/1ps
module tb_top;
    import pmc_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    pmc_pins_t drv, pins;
    logic active = 1'b0;
    logic done_n, tbase, c0l, c0h, c1l, c1h, mux, ewa, ewb, rstn, irq, poe, zwe, rde, col_low;
    logic [1:0] rs0, rs1;
    logic s_col, s_lo, s_hi, s_b0, s_b1, s_zw, s_rdy, s_ew, s_mux, do_ref, hit, wr;
    int err_total = 0;
    int checked = 0;
    int seed = 43029;
    int last_tag = -1;
    int tag, k, ws;

    always #2.5 i_ref_clk = ~i_ref_clk;
    assign col_low = !(c0l & c0h & c1l & c1h);
    always_comb begin
        pins = drv;
        pins.cycle_done_n = done_n;
        pins.fixed_timebase = tbase;
    end

    pmc_ctrl u_pmc_ctrl (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_pins(pins),
        .o_row_strobes_b0_n(rs0), .o_row_strobes_b1_n(rs1), .o_col_strobe_b0_lo_n(c0l),
        .o_col_strobe_b0_hi_n(c0h), .o_col_strobe_b1_lo_n(c1l), .o_col_strobe_b1_hi_n(c1h),
        .o_row_col_mux_sel(mux), .o_early_write_a_n(ewa), .o_early_write_b_n(ewb),
        .o_zero_wait_req_out(), .o_zero_wait_req_oe(zwe), .o_bus_ready_out(), .o_bus_ready_oe(rde),
        .o_reset_n(rstn), .o_rtc_irq_out(irq), .o_pins_oe(poe));
    pmc_bus_model u_pmc_bus_model (.i_ref_clk(i_ref_clk), .i_active(active), .i_col_low(col_low),
        .i_ready_oe(rde), .i_delay(4'h2), .o_cycle_done_n(done_n), .o_timebase(tbase));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One memory cycle; a hold cycle is ended by the bench raising its strobe, a processor one by the partner.
    task automatic run_cycle(input logic hold);
        int n;
        {s_col, s_lo, s_hi, s_b0, s_b1, s_zw, s_rdy, s_ew, s_mux} = '0;
        @(negedge i_ref_clk);
        if (hold) begin
            drv.bus_mem_read_n = wr;
            drv.bus_mem_write_n = !wr;
        end else begin
            drv.cpu_status1_n = wr;
            drv.cpu_status0_n = !wr;
            active = 1'b1;
        end
        for (n = 0; n < 60; n++) begin
            @(negedge i_ref_clk);
            s_lo |= !c0l || !c1l;
            s_hi |= !c0h || !c1h;
            s_b0 |= !(c0l & c0h);
            s_b1 |= !(c1l & c1h);
            s_zw |= zwe;
            s_rdy |= rde;
            s_ew |= !ewa && !ewb;
            if (n == 12 && do_ref) begin
                drv.refresh_n = 1'b0;
            end
            if (n > 16 && n < 24) begin
                s_mux |= mux;
            end
            if (hold && n > 24) begin
                drv.bus_mem_read_n = 1'b1;
                drv.bus_mem_write_n = 1'b1;
            end
            if (s_col && !col_low) begin
                break;
            end
            s_col |= col_low;
        end
        check({7'h0, ewa & ewb}, 8'h01, "write strobe at end");
        drv.cpu_status1_n = 1'b1;
        drv.cpu_status0_n = 1'b1;
        drv.bus_mem_read_n = 1'b1;
        drv.bus_mem_write_n = 1'b1;
        drv.refresh_n = 1'b1;
        active = 1'b0;
        repeat (10) @(negedge i_ref_clk);
    endtask

    task automatic rand_lanes();
        drv.cpu_addr_bit0 = 1'($random(seed));
        drv.cpu_high_byte_en_n = !drv.cpu_addr_bit0 & 1'($random(seed));
        drv.ext_addr_bit0 = 1'($random(seed));
        drv.ext_high_byte_en_n = !drv.ext_addr_bit0 & 1'($random(seed));
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        drv = '0;
        {drv.cpu_status0_n, drv.cpu_status1_n, drv.cpu_high_byte_en_n, drv.ext_high_byte_en_n} = 4'hf;
        {drv.bus_mem_read_n, drv.bus_mem_write_n, drv.refresh_n, drv.interleave_en_n} = 4'hf;
        {drv.test_n, drv.rtc_irq_in_n, drv.mem_io_sel, drv.onboard_mem_hit} = 4'hf;
        {drv.bank0_col_enable, drv.bank0_row_enable} = 2'h3;
        do_ref = 1'b0;
        repeat (10) @(negedge i_ref_clk);
        check({rs0, rs1, c0l, c0h, c1l, c1h}, 8'hff, "strobes in reset");
        check({7'h0, rstn}, 8'h00, "reset out in reset");
        i_rst = 1'b0;
        repeat (10) @(negedge i_ref_clk);
        check({7'h0, rstn}, 8'h01, "reset out");
        drv.rtc_irq_in_n = 1'b0;
        repeat (6) @(negedge i_ref_clk);
        check({7'h0, irq}, 8'h01, "irq out");
        drv.rtc_irq_in_n = 1'b1;
        $display("test reset done");
        for (k = 0; k < 12; k++) begin
            wr = (k % 4 == 3);
            // last third interleaved on bank 1
            drv.interleave_en_n = 1'(k < 8);
            drv.cpu_addr_bit9 = 1'(k >= 8);
            tag = (!wr && k % 2 == 1 && last_tag >= 0) ? last_tag : ($random(seed) & 32'h7fff);
            hit = !wr && tag == last_tag;
            drv.upper_addr_bits = tag[14:0];
            rand_lanes();
            run_cycle(1'b0);
            last_tag = wr ? -1 : tag;
            check({7'h0, s_zw}, {7'h0, hit}, "zero wait on hit");
            check({7'h0, s_rdy}, {7'h0, !hit}, "two waits on miss or write");
            check({6'h0, s_lo, s_hi}, {6'h0, !drv.cpu_addr_bit0, !drv.cpu_high_byte_en_n}, "lanes");
            check({6'h0, s_b1, s_ew}, {6'h0, 1'(k >= 8), wr}, "bank and early write");
        end
        $display("test page mode done");
        drv.onboard_mem_hit = 1'b0;
        wr = 1'b0;
        run_cycle(1'b0);
        check({7'h0, s_col}, 8'h00, "off-board read");
        drv.shadow_copy_active = 1'b1;
        wr = 1'b1;
        run_cycle(1'b0);
        check({7'h0, s_col}, 8'h01, "shadow write");
        {drv.onboard_mem_hit, drv.shadow_copy_active} = 2'h2;
        $display("test on-board decode done");
        drv.page_mode_n = 1'b1;
        {drv.bank0_col_enable, drv.bank0_row_enable, drv.bank1_col_enable, drv.bank1_row_enable} = 4'h3;
        for (ws = 0; ws < 4; ws++) begin
            wr = ws[1];
            {drv.write_wait_sel, drv.read_wait_sel} = {2{ws[0]}};
            rand_lanes();
            repeat (8) @(negedge i_ref_clk);
            run_cycle(1'b0);
            check({6'h0, s_rdy, s_b0}, {6'h0, ws[0], 1'b0}, "normal waits and bank");
        end
        $display("test normal mode done");
        drv.hold_ack_in = 1'b1;
        do_ref = 1'b1;
        wr = 1'b0;
        rand_lanes();
        run_cycle(1'b1);
        check({6'h0, s_lo, s_hi}, {6'h0, !drv.ext_addr_bit0, !drv.ext_high_byte_en_n}, "ext lanes");
        check({6'h0, s_rdy, s_mux}, 8'h00, "hold ready and refresh mux");
        do_ref = 1'b0;
        drv.hold_ack_in = 1'b0;
        $display("test hold mode done");
        drv.test_n = 1'b0;
        repeat (6) @(negedge i_ref_clk);
        check({7'h0, poe}, 8'h00, "outputs floated");
        drv.test_n = 1'b1;
        repeat (6) @(negedge i_ref_clk);
        check({7'h0, poe}, 8'h01, "outputs driven");
        $display("test float done");
        stop_test();
    end

    // A stuck handshake would otherwise hang the run; the span is well above the longest test.
    initial begin
        #100000;
        err_total++;
        $display("wrong value at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule // tb_top
